// ==== mon_regs.svh ====
// register offsets, field positions, reset values and scaling for the monitor sequencer
`ifndef MON_REGS_SVH
`define MON_REGS_SVH

// ==========================================================
// register offsets
`define MON_OFS_CONFIG   8'h00
`define MON_OFS_SHUNT    8'h01
`define MON_OFS_BUS      8'h02
`define MON_OFS_POWER    8'h03
`define MON_OFS_CURRENT  8'h04
`define MON_OFS_CAL      8'h05
`define MON_OFS_MASK     8'h06
`define MON_OFS_LIMIT    8'h07

// ==========================================================
// fields
`define MON_CFG_AVG_MSB  11
`define MON_CFG_AVG_LSB  9
`define MON_MSK_SOL      15
`define MON_MSK_SUL      14
`define MON_MSK_BOL      13
`define MON_MSK_BUL      12
`define MON_MSK_POL      11
`define MON_MSK_ROUTE    10
`define MON_MSK_LFLAG    4
`define MON_MSK_CONVERSION_READY_FLAG     3
`define MON_MSK_ALERT_POLARITY     1
`define MON_MSK_LEN      0
`define MON_MSK_WMASK    16'hfc03

// ==========================================================
// reset values
`define MON_CFG_RESET    16'h0007
`define MON_MASK_RESET   16'h0000
`define MON_LIMIT_RESET  16'h0000
`define MON_CAL_RESET    16'h0000

// ==========================================================
// scaling
`define MON_BUS_LSB_UV   1250
`define MON_BUS_FS_MV    40960
`define MON_BUS_MAX      16'h7fff
`define MON_CUR_SHIFT    11
`define MON_PWR_SHIFT    3
`define MON_REQ_GAP      2'h3

`endif

// ==== mon_pkg.sv ====
// types shared by the monitor sequencer
package mon_pkg;

  typedef enum logic [2:0] {
    MON_MODE_OFF0    = 3'h0,
    MON_MODE_SH_TRIG = 3'h1,
    MON_MODE_BU_TRIG = 3'h2,
    MON_MODE_SB_TRIG = 3'h3,
    MON_MODE_OFF4    = 3'h4,
    MON_MODE_SH_CONT = 3'h5,
    MON_MODE_BU_CONT = 3'h6,
    MON_MODE_SB_CONT = 3'h7
  } mon_mode_t;

  typedef enum logic [2:0] {
    MON_ST_IDLE     = 3'b000,
    MON_ST_SH_REQ   = 3'b001,
    MON_ST_SH_WAIT  = 3'b010,
    MON_ST_BUS_REQ  = 3'b011,
    MON_ST_BUS_WAIT = 3'b100,
    MON_ST_SEQ_END  = 3'b101
  } mon_state_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] current;
    logic [15:0] power;
  } mon_result_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mon_reg_req_t;

endpackage

// ==== mon_sequencer.sv ====
// conversion sequencer, arithmetic, averaging, ready flag and alert of the monitor
`timescale 1ns/1ns
`include "mon_regs.svh"
module mon_sequencer
  import mon_pkg::*;
(
  // core clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // register access from the serial protocol engine, link clock domain
  input  wire logic         link_clk,
  input  wire mon_reg_req_t reg_req,
  output logic [15:0]       reg_rdata,
  // converter front end
  output logic              adc_req,
  output logic              adc_sel_bus,
  input  wire logic         adc_done,
  input  wire logic [15:0]  adc_data,
  // open-drain alert pin
  output logic              alert_out,
  output logic              alert_oe_n
);

  // ==========================================================
  // link domain: host registers
  logic [15:0] cfg_l, cal_l, mask_l, limit_l;
  logic        calw_l, last_cfg_l, wr_tgl, clr_tgl;
  logic [15:0] next_cfg_l, next_cal_l, next_mask_l, next_limit_l, next_rdata;
  logic        next_calw_l, next_last_cfg_l, next_wr_tgl, next_clr_tgl;
  mon_result_t shadow, next_shadow, res;
  logic        pub_s1, pub_s2, pub_s3;
  logic [1:0]  flg_s1, flg_s2;
  logic        pub_tgl, conversion_ready_flag, lflag;

  always_comb begin
    next_cfg_l      = cfg_l;
    next_cal_l      = cal_l;
    next_mask_l     = mask_l;
    next_limit_l    = limit_l;
    next_calw_l     = calw_l;
    next_last_cfg_l = last_cfg_l;
    next_wr_tgl     = wr_tgl;
    next_clr_tgl    = clr_tgl;
    next_rdata      = reg_rdata;
    next_shadow     = shadow;
    // copy published results only on a fresh toggle, so they stay put between cycles
    if (pub_s2 != pub_s3) begin
      next_shadow = res;
    end
    if (reg_req.wr) begin
      next_wr_tgl     = ~wr_tgl;
      next_last_cfg_l = (reg_req.addr == `MON_OFS_CONFIG);
      case (reg_req.addr)
        `MON_OFS_CONFIG: next_cfg_l = reg_req.wdata;
        `MON_OFS_CAL: begin
          next_cal_l  = reg_req.wdata;
          next_calw_l = 1'b1;
        end
        `MON_OFS_MASK:  next_mask_l  = reg_req.wdata & `MON_MSK_WMASK;
        `MON_OFS_LIMIT: next_limit_l = reg_req.wdata;
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        `MON_OFS_CONFIG:  next_rdata = cfg_l;
        `MON_OFS_SHUNT:   next_rdata = shadow.shunt;
        `MON_OFS_BUS:     next_rdata = shadow.bus;
        `MON_OFS_POWER:   next_rdata = shadow.power;
        `MON_OFS_CURRENT: next_rdata = shadow.current;
        `MON_OFS_CAL:     next_rdata = cal_l;
        `MON_OFS_MASK: begin
          next_rdata = mask_l;
          next_rdata[`MON_MSK_LFLAG] = flg_s2[1];
          next_rdata[`MON_MSK_CONVERSION_READY_FLAG]  = flg_s2[0];
          next_clr_tgl = ~clr_tgl;
        end
        `MON_OFS_LIMIT:   next_rdata = limit_l;
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_l      <= `MON_CFG_RESET;
      cal_l      <= `MON_CAL_RESET;
      mask_l     <= `MON_MASK_RESET;
      limit_l    <= `MON_LIMIT_RESET;
      calw_l     <= 1'b0;
      last_cfg_l <= 1'b0;
      wr_tgl     <= 1'b0;
      clr_tgl    <= 1'b0;
      reg_rdata  <= 16'h0000;
      shadow     <= '0;
    end else begin
      cfg_l      <= next_cfg_l;
      cal_l      <= next_cal_l;
      mask_l     <= next_mask_l;
      limit_l    <= next_limit_l;
      calw_l     <= next_calw_l;
      last_cfg_l <= next_last_cfg_l;
      wr_tgl     <= next_wr_tgl;
      clr_tgl    <= next_clr_tgl;
      reg_rdata  <= next_rdata;
      shadow     <= next_shadow;
    end
  end

  // ==========================================================
  // link domain synchronisers for core events and flags
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      pub_s1 <= 1'b0;
      pub_s2 <= 1'b0;
      pub_s3 <= 1'b0;
      flg_s1 <= 2'b00;
      flg_s2 <= 2'b00;
    end else begin
      pub_s1 <= pub_tgl;
      pub_s2 <= pub_s1;
      pub_s3 <= pub_s2;
      flg_s1 <= {lflag, conversion_ready_flag};
      flg_s2 <= flg_s1;
    end
  end

  // ==========================================================
  // core domain synchronisers
  // host words are quasi-static: sampled only after the write toggle has settled
  logic wr_s1, wr_s2, wr_s3, clr_s1, clr_s2, clr_s3, done_s1, done_s2, done_s3;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_s1   <= 1'b0;
      wr_s2   <= 1'b0;
      wr_s3   <= 1'b0;
      clr_s1  <= 1'b0;
      clr_s2  <= 1'b0;
      clr_s3  <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      wr_s1   <= wr_tgl;
      wr_s2   <= wr_s1;
      wr_s3   <= wr_s2;
      clr_s1  <= clr_tgl;
      clr_s2  <= clr_s1;
      clr_s3  <= clr_s2;
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  wire wr_ev   = wr_s2 ^ wr_s3;
  wire clr_ev  = clr_s2 ^ clr_s3;
  wire done_rise = done_s2 & ~done_s3;

  // ==========================================================
  // core arithmetic, combinational so it never lengthens a conversion
  logic [15:0]        cfg_c, cal_c, mask_c, limit_c;
  logic               calw_c;
  logic signed [15:0] sh_last, cur_last;
  logic [15:0]        bus_last, pwr_last;
  logic signed [32:0] cur_prod;
  logic [31:0]        pwr_prod;
  logic [15:0]        cur_mag, bus_conv;
  logic signed [15:0] cur_calc;
  logic [15:0]        pwr_calc;

  always_comb begin
    bus_conv = (adc_data > `MON_BUS_MAX) ? `MON_BUS_MAX : adc_data;
    cur_prod = $signed(adc_data) * $signed({1'b0, cal_c});
    cur_calc = calw_c ? cur_prod[`MON_CUR_SHIFT+15:`MON_CUR_SHIFT] : 16'sh0000;
    cur_mag  = cur_last[15] ? 16'(-cur_last) : cur_last;
    pwr_prod = cur_mag * bus_conv;
    pwr_calc = calw_c ? pwr_prod[`MON_PWR_SHIFT+15:`MON_PWR_SHIFT] : 16'h0000;
  end

  // most significant enabled limit function wins
  logic [4:0] fn_sel;
  always_comb begin
    fn_sel = 5'h00;
    if (mask_c[`MON_MSK_SOL])      fn_sel = 5'h10;
    else if (mask_c[`MON_MSK_SUL]) fn_sel = 5'h08;
    else if (mask_c[`MON_MSK_BOL]) fn_sel = 5'h04;
    else if (mask_c[`MON_MSK_BUL]) fn_sel = 5'h02;
    else if (mask_c[`MON_MSK_POL]) fn_sel = 5'h01;
  end

  // averaging count as a shift: 1,4,16,64,128,256,512,1024
  logic [3:0] avg_sh;
  always_comb begin
    case (cfg_c[`MON_CFG_AVG_MSB:`MON_CFG_AVG_LSB])
      3'h0:    avg_sh = 4'h0;
      3'h1:    avg_sh = 4'h2;
      3'h2:    avg_sh = 4'h4;
      3'h3:    avg_sh = 4'h6;
      3'h4:    avg_sh = 4'h7;
      3'h5:    avg_sh = 4'h8;
      3'h6:    avg_sh = 4'h9;
      default: avg_sh = 4'ha;
    endcase
  end

  // ==========================================================
  // core sequencer state
  mon_state_t          state, next_state;
  logic signed [25:0]  acc_sh, acc_cur, next_acc_sh, next_acc_cur;
  logic [25:0]         acc_bus, acc_pwr, next_acc_bus, next_acc_pwr;
  logic [10:0]         seq_cnt, next_seq_cnt;
  mon_result_t         next_res;
  logic [15:0]         next_cfg_c, next_cal_c, next_mask_c, next_limit_c;
  logic signed [15:0]  next_sh_last, next_cur_last;
  logic [15:0]         next_bus_last, next_pwr_last;
  logic                next_calw_c, next_conversion_ready_flag, next_lflag, next_pub_tgl;
  logic                next_adc_req, next_adc_sel, next_alert_oe_n;
  logic                hit, hit_valid, set_conversion_ready_flag;
  logic [1:0]          gap, next_gap;

  always_comb begin
    next_state    = state;
    next_acc_sh   = acc_sh;
    next_acc_bus  = acc_bus;
    next_acc_cur  = acc_cur;
    next_acc_pwr  = acc_pwr;
    next_seq_cnt  = seq_cnt;
    next_res      = res;
    next_cfg_c    = cfg_c;
    next_cal_c    = cal_c;
    next_mask_c   = mask_c;
    next_limit_c  = limit_c;
    next_calw_c   = calw_c;
    next_sh_last  = sh_last;
    next_cur_last = cur_last;
    next_bus_last = bus_last;
    next_pwr_last = pwr_last;
    next_pub_tgl  = pub_tgl;
    next_adc_req  = adc_req;
    next_adc_sel  = adc_sel_bus;
    next_conversion_ready_flag     = conversion_ready_flag;
    next_lflag    = lflag;
    hit           = 1'b0;
    hit_valid     = 1'b0;
    set_conversion_ready_flag      = 1'b0;
    // idle cycles since request fell; a restart must outwait a done in flight
    next_gap      = adc_req ? 2'h0 : ((gap == `MON_REQ_GAP) ? gap : gap + 2'h1);

    case (state)
      MON_ST_IDLE: next_adc_req = 1'b0;
      MON_ST_SH_REQ: begin
        // four-phase with the front end: wait for done to fall first
        if (!done_s2 && gap == `MON_REQ_GAP) begin
          next_adc_req = 1'b1;
          next_adc_sel = 1'b0;
          next_state   = MON_ST_SH_WAIT;
        end
      end
      MON_ST_SH_WAIT: begin
        if (done_rise) begin
          next_adc_req  = 1'b0;
          next_sh_last  = adc_data;
          next_cur_last = cur_calc;
          hit_valid     = fn_sel[4] | fn_sel[3];
          hit           = fn_sel[4] ? ($signed(adc_data) > $signed(limit_c))
                                    : ($signed(adc_data) < $signed(limit_c));
          next_state    = cfg_c[1] ? MON_ST_BUS_REQ : MON_ST_SEQ_END;
        end
      end
      MON_ST_BUS_REQ: begin
        if (!done_s2 && gap == `MON_REQ_GAP) begin
          next_adc_req = 1'b1;
          next_adc_sel = 1'b1;
          next_state   = MON_ST_BUS_WAIT;
        end
      end
      MON_ST_BUS_WAIT: begin
        if (done_rise) begin
          next_adc_req  = 1'b0;
          next_bus_last = bus_conv;
          next_pwr_last = pwr_calc;
          hit_valid     = |fn_sel[2:0];
          hit           = fn_sel[2] ? (bus_conv > limit_c) :
                          fn_sel[1] ? (bus_conv < limit_c) : (pwr_calc > limit_c);
          next_state    = MON_ST_SEQ_END;
        end
      end
      MON_ST_SEQ_END: begin
        next_acc_sh  = acc_sh + 26'(sh_last);
        next_acc_bus = acc_bus + 26'(bus_last);
        next_acc_cur = acc_cur + 26'(cur_last);
        next_acc_pwr = acc_pwr + 26'(pwr_last);
        next_seq_cnt = seq_cnt + 11'h001;
        if (next_seq_cnt == (11'h001 << avg_sh)) begin
          if (avg_sh == 4'h0) begin
            next_res = '{sh_last, bus_last, cur_last, pwr_last};
          end else begin
            next_res.shunt   = 16'(next_acc_sh >>> avg_sh);
            next_res.bus     = 16'(next_acc_bus >> avg_sh);
            next_res.current = 16'(next_acc_cur >>> avg_sh);
            next_res.power   = 16'(next_acc_pwr >> avg_sh);
          end
          next_pub_tgl = ~pub_tgl;
          set_conversion_ready_flag     = 1'b1;
          next_acc_sh  = '0;
          next_acc_bus = '0;
          next_acc_cur = '0;
          next_acc_pwr = '0;
          next_seq_cnt = '0;
          next_state   = cfg_c[2] ? (cfg_c[0] ? MON_ST_SH_REQ : MON_ST_BUS_REQ)
                                  : MON_ST_IDLE;
        end else begin
          next_state = cfg_c[0] ? MON_ST_SH_REQ : MON_ST_BUS_REQ;
        end
      end
      default: next_state = MON_ST_IDLE;
    endcase

    // host write: latch the settled words, then act on a configuration write
    if (wr_ev) begin
      next_cfg_c   = cfg_l;
      next_cal_c   = cal_l;
      next_mask_c  = mask_l;
      next_limit_c = limit_l;
      next_calw_c  = calw_l;
      if (last_cfg_l) begin
        next_lflag = 1'b0;
        if (cfg_l[1:0] != 2'b00) begin
          next_conversion_ready_flag    = 1'b0;
          next_acc_sh  = '0;
          next_acc_bus = '0;
          next_acc_cur = '0;
          next_acc_pwr = '0;
          next_seq_cnt = '0;
          next_adc_req = 1'b0;
          next_state   = cfg_l[0] ? MON_ST_SH_REQ : MON_ST_BUS_REQ;
        end else begin
          next_adc_req = 1'b0;
          next_state   = MON_ST_IDLE;
        end
      end
    end
    if (clr_ev) begin
      next_conversion_ready_flag  = 1'b0;
      next_lflag = 1'b0;
    end
    // hardware set beats a clear landing in the same cycle
    if (set_conversion_ready_flag) begin
      next_conversion_ready_flag = 1'b1;
    end
    if (hit_valid) begin
      if (mask_c[`MON_MSK_LEN]) next_lflag = next_lflag | hit;
      else                      next_lflag = hit;
    end

    // pin pulled low when the active level is low and alert is on, or the reverse
    next_alert_oe_n = ~(mask_c[`MON_MSK_ALERT_POLARITY] ^
                        (next_lflag | (mask_c[`MON_MSK_ROUTE] & next_conversion_ready_flag)));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= MON_ST_SH_REQ;
      acc_sh      <= '0;
      acc_bus     <= '0;
      acc_cur     <= '0;
      acc_pwr     <= '0;
      seq_cnt     <= '0;
      res         <= '0;
      cfg_c       <= `MON_CFG_RESET;
      cal_c       <= `MON_CAL_RESET;
      mask_c      <= `MON_MASK_RESET;
      limit_c     <= `MON_LIMIT_RESET;
      calw_c      <= 1'b0;
      sh_last     <= '0;
      cur_last    <= '0;
      bus_last    <= '0;
      pwr_last    <= '0;
      pub_tgl     <= 1'b0;
      adc_req     <= 1'b0;
      adc_sel_bus <= 1'b0;
      conversion_ready_flag        <= 1'b0;
      lflag       <= 1'b0;
      gap         <= `MON_REQ_GAP;
      alert_oe_n  <= 1'b1;
      alert_out   <= 1'b0;
    end else begin
      state       <= next_state;
      acc_sh      <= next_acc_sh;
      acc_bus     <= next_acc_bus;
      acc_cur     <= next_acc_cur;
      acc_pwr     <= next_acc_pwr;
      seq_cnt     <= next_seq_cnt;
      res         <= next_res;
      cfg_c       <= next_cfg_c;
      cal_c       <= next_cal_c;
      mask_c      <= next_mask_c;
      limit_c     <= next_limit_c;
      calw_c      <= next_calw_c;
      sh_last     <= next_sh_last;
      cur_last    <= next_cur_last;
      bus_last    <= next_bus_last;
      pwr_last    <= next_pwr_last;
      pub_tgl     <= next_pub_tgl;
      adc_req     <= next_adc_req;
      adc_sel_bus <= next_adc_sel;
      conversion_ready_flag        <= next_conversion_ready_flag;
      lflag       <= next_lflag;
      gap         <= next_gap;
      alert_oe_n  <= next_alert_oe_n;
      alert_out   <= 1'b0;
    end
  end

endmodule

// ==== mon_seq_properties.sv ====
// port checker for the monitor sequencer
`timescale 1ns/1ns
module mon_seq_properties
  import mon_pkg::*;
(
  // clocks and reset
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         link_clk,
  // register port
  input wire mon_reg_req_t reg_req,
  input wire logic [15:0]  reg_rdata,
  // front end and alert
  input wire logic         adc_req,
  input wire logic         adc_sel_bus,
  input wire logic         adc_done,
  input wire logic         alert_out,
  input wire logic         alert_oe_n
);
  // ==========================================
  // front end handshake
  start_req_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) && !adc_done |=> adc_req) else $error("no request after reset");
  req_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    adc_req && adc_done |-> ##[1:4] !adc_req) else $error("request held after done");
  req_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(adc_req) |-> !adc_done) else $error("request while done high");
  sel_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    adc_req && $past(adc_req) |-> $stable(adc_sel_bus)) else $error("select moved");
  // ==========================================
  // power-down, long window since the write must first cross into the core, which then drops the request at once
  pd_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == 8'h00 && reg_req.wdata[2:0] == 3'h0
    |-> ##30 !adc_req [*8]) else $error("conversion in power-down");
  // ==========================================
  // register port and alert pin
  rdata_hold_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    !reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
  mask_bits_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    reg_req.rd && reg_req.addr == 8'h06 |=> reg_rdata[9:5] == 5'h00 && !reg_rdata[2])
    else $error("mask reserved bits set");
  pin_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    alert_out == 1'b0) else $error("alert drives high");
endmodule

bind mon_sequencer mon_seq_properties u_props (
  .clk, .reset_n, .link_clk, .reg_req, .reg_rdata, .adc_req,
  .adc_sel_bus, .adc_done, .alert_out, .alert_oe_n
);

// ==== mon_adc_model.sv ====
// converter front end model, four-phase handshake
`timescale 1ns/1ns
module mon_adc_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // handshake
  input  wire logic        adc_req,
  input  wire logic        adc_sel_bus,
  output logic             adc_done,
  output logic [15:0]      adc_data,
  // bench controls
  input  wire logic [15:0] shunt_code,
  input  wire logic [15:0] bus_code,
  input  wire logic [7:0]  wait_cycles,
  output logic [15:0]      sh_count,
  output logic [15:0]      bu_count
);
  logic [7:0] cnt;
  // ==========================================
  // conversion; data toggles whenever it is not valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
      cnt <= 8'h00;
      sh_count <= 16'h0000;
      bu_count <= 16'h0000;
    end else if (adc_req && !adc_done) begin
      if (cnt >= wait_cycles) begin
        adc_done <= 1'b1;
        adc_data <= adc_sel_bus ? bus_code : shunt_code;
        cnt <= 8'h00;
        if (adc_sel_bus) begin
          bu_count <= bu_count + 16'h0001;
        end else begin
          sh_count <= sh_count + 16'h0001;
        end
      end else begin
        cnt <= cnt + 8'h01;
        adc_data <= ~adc_data;
      end
    end else if (!adc_req) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
    end
  end
endmodule

// ==== mon_sequencer_tb.sv ====
// self-checking bench for the monitor sequencer
`timescale 1ns/1ns
module mon_sequencer_tb
  import mon_pkg::*;
;
  logic         clk = 1'b0;
  logic         link_clk = 1'b0;
  logic         reset_n;
  mon_reg_req_t reg_req;
  logic [15:0]  reg_rdata;
  logic         adc_req;
  logic         adc_sel_bus;
  logic         adc_done;
  logic [15:0]  adc_data;
  logic         alert_out;
  logic         alert_oe_n;
  logic [15:0]  shunt;
  logic [15:0]  bus;
  logic [7:0]   wcyc;
  logic [15:0]  sh_count;
  logic [15:0]  bu_count;
  int           fail_count = 0;
  int           check_count = 0;
  int           cyc = 0;

  always #50 clk = ~clk;
  always begin
    #63 link_clk = ~link_clk;
    #62 link_clk = ~link_clk;
  end

  mon_sequencer u_dut (.clk, .reset_n, .link_clk, .reg_req, .reg_rdata, .adc_req,
    .adc_sel_bus, .adc_done, .adc_data, .alert_out, .alert_oe_n);
  mon_adc_model u_adc (.clk, .reset_n, .adc_req, .adc_sel_bus, .adc_done, .adc_data,
    .shunt_code(shunt), .bus_code(bus), .wait_cycles(wcyc), .sh_count, .bu_count);

  // ==========================================
  // shared tasks
  task automatic summarize;
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wl(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // spacing after a write covers the core's crossing time
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge link_clk) #5 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge link_clk) #5 reg_req = '0;
    wl(8);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge link_clk) #5 reg_req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge link_clk) #5 reg_req = '0;
    check16(reg_rdata & m, e);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    wl(40);
    rd_chk(8'h00, 16'hffff, 16'h0007);
    rd_chk(8'h05, 16'hffff, 16'h0000);
    rd_chk(8'h06, 16'hffe7, 16'h0000);
    rd_chk(8'h07, 16'hffff, 16'h0000);
    rd_chk(8'h09, 16'hffff, 16'h0000);
    rd_chk(8'h04, 16'hffff, 16'h0000);
    rd_chk(8'h03, 16'hffff, 16'h0000);
    rd_chk(8'h02, 16'hffff, 16'h0080);
    rd_chk(8'h01, 16'hffff, 16'h0800);
  endtask
  task automatic t_calc;
    reg_wr(8'h05, 16'h0400);
    reg_wr(8'h00, 16'h0007);
    wl(40);
    rd_chk(8'h04, 16'hffff, 16'h0400);
    rd_chk(8'h03, 16'hffff, 16'h4000);
  endtask
  task automatic t_single;
    logic [15:0] s0;
    logic [15:0] b0;
    for (int m = 1; m < 4; m++) begin
      reg_wr(8'h00, 16'h0000);
      wl(40);
      s0 = sh_count;
      b0 = bu_count;
      reg_wr(8'h00, 16'(m));
      wl(40);
      check16(sh_count - s0, 16'(m & 1));
      check16(bu_count - b0, 16'(m >> 1));
      rd_chk(8'h06, 16'h0008, 16'h0008);
      wl(8);
      rd_chk(8'h06, 16'h0008, 16'h0000);
    end
    // slow front end, averaging of four, same value written twice
    wcyc = 8'd20;
    for (int k = 0; k < 2; k++) begin
      s0 = sh_count;
      b0 = bu_count;
      reg_wr(8'h00, 16'h0203);
      wl(52);
      rd_chk(8'h06, 16'h0008, 16'h0000);
      wl(240);
      rd_chk(8'h06, 16'h0008, 16'h0008);
      check16(sh_count - s0, 16'h0004);
      check16(bu_count - b0, 16'h0004);
      rd_chk(8'h01, 16'hffff, 16'h0800);
    end
    wcyc = 8'd4;
  endtask
  task automatic t_pd;
    logic [15:0] s0;
    logic [15:0] b0;
    reg_wr(8'h00, 16'h0004);
    wl(40);
    s0 = sh_count;
    wl(40);
    check16(sh_count, s0);
    reg_wr(8'h07, 16'h1234);
    rd_chk(8'h07, 16'hffff, 16'h1234);
    reg_wr(8'h00, 16'h0005);
    b0 = bu_count;
    wl(40);
    check16({15'h0000, sh_count != s0}, 16'h0001);
    check16(bu_count - b0, 16'h0000);
  endtask
  task automatic t_alert;
    logic [15:0] msk [4] = '{16'h2000, 16'ha000, 16'h0002, 16'h0400};
    logic        exp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk) #5 shunt = 16'h0010;
    reg_wr(8'h00, 16'h0007);
    reg_wr(8'h07, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h06, msk[i]);
      wl(40);
      check16({15'h0000, alert_oe_n}, {15'h0000, exp[i]});
    end
    reg_wr(8'h06, 16'h2001);
    wl(40);
    check16({15'h0000, alert_oe_n}, 16'h0000);
    @(posedge clk) #5 bus = 16'h0010;
    wl(40);
    check16({15'h0000, alert_oe_n}, 16'h0000);
    rd_chk(8'h06, 16'h0010, 16'h0010);
    wl(40);
    check16({15'h0000, alert_oe_n}, 16'h0001);
  endtask

  // ==========================================
  // hang guard, run needs about 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    shunt = 16'h0800;
    bus = 16'h0080;
    wcyc = 8'd4;
    repeat (12) @(posedge clk);
    #5 reset_n = 1'b1;
    t_reset();
    t_calc();
    t_single();
    t_pd();
    t_alert();
    summarize();
  end
endmodule
